// ==== common/lsp_cfg.svh ====
// Purpose: Timing counts and reset values for the lamp switch PWM output control
// Assumes: ref_clk at 20 MHz
// Notes: All cycle counts derive from the printed times and the clock rate
`ifndef LSP_CFG_SVH
`define LSP_CFG_SVH

`define LSP_CLK_HZ 20000000
`define LSP_CLK_MHZ 20
`define LSP_CLK_KHZ 20000

// PWM resolution, steps per output period
`define LSP_PWM_STEPS 256
`define LSP_PWM_MAX_HZ 1000
`define LSP_PWM_DEF_HZ 120

// Internal tick divider: default and least value (round up keeps under 1 kHz)
`define LSP_DIV_DEF_CYC (`LSP_CLK_HZ / (`LSP_PWM_DEF_HZ * `LSP_PWM_STEPS))
`define LSP_DIV_MIN_CYC ((`LSP_CLK_HZ + `LSP_PWM_MAX_HZ * `LSP_PWM_STEPS - 1) / (`LSP_PWM_MAX_HZ * `LSP_PWM_STEPS))

// Calibration pulse window on chip select
`define LSP_CAL_MIN_US 20
`define LSP_CAL_MAX_US 200
`define LSP_CAL_MIN_CYC (`LSP_CAL_MIN_US * `LSP_CLK_MHZ)
`define LSP_CAL_MAX_CYC (`LSP_CAL_MAX_US * `LSP_CLK_MHZ)

// External clock fail thresholds
`define LSP_FAIL_LO_HZ 2000
`define LSP_FAIL_HI_HZ 200000
`define LSP_FAIL_LO_CYC (`LSP_CLK_HZ / `LSP_FAIL_LO_HZ)
`define LSP_FAIL_HI_CYC (`LSP_CLK_HZ / `LSP_FAIL_HI_HZ)

// Long timers
`define LSP_TOGGLE_TMO_MS 250
`define LSP_AUTORETRY_MS 150
`define LSP_TOGGLE_TMO_CYC (`LSP_TOGGLE_TMO_MS * `LSP_CLK_KHZ)
`define LSP_AUTORETRY_CYC (`LSP_AUTORETRY_MS * `LSP_CLK_KHZ)

// Sense feedback select codes
`define LSP_SENSE_TEMP 3'h4
`define LSP_SENSE_HIZ 3'h7

// Duty code that means fully on
`define LSP_DUTY_FULL 8'hFF

`endif

// ==== common/lsp_pkg.sv ====
// Purpose: Types for the lamp switch PWM output control
// Assumes: Counter widths cover every count in lsp_cfg.svh
// Notes: Long counters are 24 bits
package lsp_pkg;

   typedef logic [23:0] lsp_long_t;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b01,
      CAL_MEAS = 2'b10
   } lsp_cal_t;

   typedef struct packed {
      lsp_cal_t cal;
      logic [12:0] cal_cnt;
      logic [12:0] tick_div;
      logic [12:0] div_cnt;
      logic ext_prev;
      logic ext_seen;
      lsp_long_t per_cnt;
      logic clk_fail;
      logic [7:0] pwm_cnt;
      logic [3:0] in_on;
      logic [3:0][23:0] tmo_cnt;
      logic wake;
      logic [3:0] sense_ch;
      logic sense_temp;
      logic sense_oe;
   } lsp_top_t;

   typedef struct packed {
      logic shut;
      lsp_long_t retry_cnt;
      logic out;
   } lsp_chan_t;

endpackage

// ==== hdl/lsp_output_ctrl.sv ====
// Purpose: Output control of a four-channel lamp switch: PWM, clock checks, wake
// Assumes: Pins arrive asynchronous to ref_clk; config bits are same-clock levels
// Notes: Tick source is the first direct input or an internal divider
`timescale 1ns/1ps
`include "lsp_cfg.svh"

// How it works
// - Flag clock fail below about 2 kHz
// - Flag clock fail above about 200 kHz
// - Fail check only when PWM on, external clock
// - Output PWM frequency never above 1 kHz
// - Calibrated oscillator PWM frequency within ten percent
// - Uncalibrated default PWM frequency about 120 Hz
// - Calibrate from chip-select low pulse, 20-200 us
// - Duty 100 percent fully on, 0 fully off
// - Direct input toggle timeout about 250 ms
// - Autoretry after shutdown every about 150 ms
// - Serial link clock at most 8 MHz
// - Sense pin shows channel current or temperature
// - Sense pin goes high impedance on command
// - Any active direct input wakes the device
// - Each direct input drives its own output
module lsp_output_ctrl #(
   parameter int unsigned TOGGLE_TMO_CYC = `LSP_TOGGLE_TMO_CYC,
   parameter int unsigned AUTORETRY_CYC = `LSP_AUTORETRY_CYC,
   parameter int unsigned FAIL_LO_CYC = `LSP_FAIL_LO_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [3:0] direct_inputs,
   input wire logic cs_n,
   input wire logic pwm_en,
   input wire logic clock_sel,
   input wire logic [3:0][7:0] duty,
   input wire logic [3:0] fault,
   input wire logic [2:0] sense_sel,
   output logic [3:0] high_side_outputs,
   output logic [3:0] retrying,
   output logic clock_fail,
   output logic wake,
   output logic [3:0] sense_ch,
   output logic sense_temp,
   output logic sense_feedback_pin_oe
);
   import lsp_pkg::*;

   localparam lsp_long_t TMO_M1 = 24'(TOGGLE_TMO_CYC - 1);
   localparam lsp_long_t LO_CYC = 24'(FAIL_LO_CYC);
   localparam lsp_long_t HI_CYC = 24'(`LSP_FAIL_HI_CYC);
   localparam logic [12:0] CAL_MIN = 13'(`LSP_CAL_MIN_CYC);
   localparam logic [12:0] CAL_MAX = 13'(`LSP_CAL_MAX_CYC);
   localparam logic [12:0] DIV_DEF = 13'(`LSP_DIV_DEF_CYC);
   localparam logic [12:0] DIV_MIN = 13'(`LSP_DIV_MIN_CYC);

   lsp_top_t s;
   lsp_top_t next_s;
   logic [1:0] rst_pipe;
   logic rst_n;
   logic [3:0] in_s;
   logic cs_s;
   logic cs_low;
   logic int_tick;
   logic ext_rise;
   logic detect;
   logic tick;
   logic pwm_mode;
   logic [3:0] hs_raw;

   if (TOGGLE_TMO_CYC < 2 || TOGGLE_TMO_CYC > 24'hFFFFFF) begin : g_chk_tmo
      $error("toggle timeout count out of range");
   end
   if (FAIL_LO_CYC <= `LSP_FAIL_HI_CYC || FAIL_LO_CYC > 24'hFFFFFF) begin : g_chk_lo
      $error("clock fail thresholds out of order");
   end
   if (`LSP_CAL_MIN_CYC < `LSP_DIV_MIN_CYC || `LSP_CAL_MAX_CYC > 8191) begin : g_chk_cal
      $error("calibration window cannot serve the tick divider");
   end

   // Reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Pin synchronisers
   lsp_sync #(.W(5)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in({~cs_n, direct_inputs}),
      .sync_out({cs_low, in_s})
   );

   // Chip select rides inverted, so the synchroniser's reset level reads as idle high
   assign cs_s = !cs_low;

   // Tick sources and PWM mode qualifiers
   always_comb begin
      int_tick = (s.div_cnt >= s.tick_div - 13'h0001);
      ext_rise = in_s[0] && !s.ext_prev;
      detect = pwm_en && !clock_sel;
      tick = pwm_en && (clock_sel ? int_tick : ext_rise);
      pwm_mode = pwm_en && !s.clk_fail;
   end

   // Next state of the whole block
   always_comb begin
      next_s = s;
      next_s.ext_prev = in_s[0];

      // Internal divider runs from the calibrated period
      if (int_tick) begin
         next_s.div_cnt = '0;
      end else begin
         next_s.div_cnt = s.div_cnt + 13'h0001;
      end

      // Shared PWM step counter, one period is 256 ticks
      if (tick) begin
         next_s.pwm_cnt = s.pwm_cnt + 8'h01;
      end

      // External clock period check
      if (detect) begin
         if (s.per_cnt != 24'hFFFFFF) begin
            next_s.per_cnt = s.per_cnt + 24'h000001;
         end
         if (ext_rise) begin
            next_s.per_cnt = '0;
            next_s.ext_seen = 1'b1;
            if (s.ext_seen && s.per_cnt < HI_CYC) begin
               next_s.clk_fail = 1'b1;
            end
         end
         if (s.per_cnt >= LO_CYC) begin
            next_s.clk_fail = 1'b1;
         end
      end else begin
         next_s.per_cnt = '0;
         next_s.ext_seen = 1'b0;
         next_s.clk_fail = 1'b0;
      end

      // Calibration pulse on chip select
      case (s.cal)
         CAL_IDLE: begin
            if (!cs_s) begin
               next_s.cal = CAL_MEAS;
               next_s.cal_cnt = 13'h0001;
            end
         end
         CAL_MEAS: begin
            if (!cs_s) begin
               if (s.cal_cnt != 13'h1FFF) begin
                  next_s.cal_cnt = s.cal_cnt + 13'h0001;
               end
            end else begin
               next_s.cal = CAL_IDLE;
               // Serial frames at up to 8 MHz are far shorter than the window: never calibrate
               if (s.cal_cnt >= CAL_MIN && s.cal_cnt <= CAL_MAX) begin
                  next_s.tick_div = (s.cal_cnt < DIV_MIN) ? DIV_MIN : s.cal_cnt;
               end
            end
         end
         default: begin
            next_s.cal = CAL_IDLE;
         end
      endcase

      // Direct input activity with toggle timeout
      for (int i = 0; i < 4; i++) begin
         if (in_s[i]) begin
            next_s.in_on[i] = 1'b1;
            next_s.tmo_cnt[i] = '0;
         end else if (s.in_on[i]) begin
            if (s.tmo_cnt[i] >= TMO_M1) begin
               next_s.in_on[i] = 1'b0;
               next_s.tmo_cnt[i] = '0;
            end else begin
               next_s.tmo_cnt[i] = s.tmo_cnt[i] + 24'h000001;
            end
         end
      end
      next_s.wake = |in_s || |s.in_on;

      // Sense feedback routing
      next_s.sense_ch = 4'h0;
      next_s.sense_temp = 1'b0;
      next_s.sense_oe = 1'b0;
      if (sense_sel < `LSP_SENSE_TEMP) begin
         next_s.sense_ch[sense_sel[1:0]] = 1'b1;
         next_s.sense_oe = 1'b1;
      end else if (sense_sel == `LSP_SENSE_TEMP) begin
         next_s.sense_temp = 1'b1;
         next_s.sense_oe = 1'b1;
      end
   end

   // State register; divider starts at the default rate
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.cal <= CAL_IDLE;
         s.tick_div <= DIV_DEF;
      end else begin
         s <= next_s;
      end
   end

   // Four output channels
   for (genvar g = 0; g < 4; g++) begin : g_chan
      lsp_pwm_chan #(.RETRY_CYC(AUTORETRY_CYC)) u_chan (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .pwm_mode(pwm_mode),
         .direct_level(in_s[g]),
         .pwm_cnt(s.pwm_cnt),
         .duty(duty[g]),
         .fault(fault[g]),
         .hs_out(hs_raw[g]),
         .retrying(retrying[g])
      );
   end

   assign high_side_outputs = hs_raw;
   assign clock_fail = s.clk_fail;
   assign wake = s.wake;
   assign sense_ch = s.sense_ch;
   assign sense_temp = s.sense_temp;
   assign sense_feedback_pin_oe = s.sense_oe;

   AST_FAIL_GATED: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(pwm_en && !clock_sel) |=> !clock_fail)
      else $error("clock fail reported while detection disabled");
   AST_FAIL_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
      detect && ext_rise && s.ext_seen && s.per_cnt < HI_CYC |=> clock_fail)
      else $error("fast external clock not flagged");
   AST_FAIL_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
      detect && s.per_cnt >= LO_CYC |=> clock_fail)
      else $error("slow external clock not flagged");
   AST_DIV_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s.tick_div >= DIV_MIN)
      else $error("tick divider allows output above limit");
   AST_CAL_WINDOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s.tick_div != $past(s.tick_div) |-> $past(s.cal_cnt) >= CAL_MIN && $past(s.cal_cnt) <= CAL_MAX)
      else $error("divider changed by pulse outside window");
   AST_TICK_RATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      int_tick |=> !int_tick [*1] ##0 s.div_cnt == 13'h0000)
      else $error("internal tick did not restart divider");
   AST_WAKE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      |in_s |=> wake ##1 wake)
      else $error("active direct input did not wake");
   AST_TOGGLE_TMO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s.in_on[0] && !in_s[0] && s.tmo_cnt[0] == TMO_M1 |=> !s.in_on[0])
      else $error("toggle timeout did not expire");
   AST_SENSE_HIZ: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sense_sel == `LSP_SENSE_HIZ |=> !sense_feedback_pin_oe && sense_ch == 4'h0)
      else $error("sense pin driven while high impedance commanded");
   AST_SENSE_CH: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sense_sel == 3'h2 |=> sense_ch == 4'h4 && !sense_temp && sense_feedback_pin_oe)
      else $error("sense pin not routed to chosen channel");
endmodule

// ==== hdl/lsp_pwm_chan.sv ====
// Purpose: One high-side output: PWM compare, direct control, autoretry
// Assumes: pwm_cnt steps once per PWM tick; fault is a same-clock level
// Notes: Output stays off for the retry period after each shutdown
`timescale 1ns/1ps
`include "lsp_cfg.svh"
module lsp_pwm_chan #(
   parameter int unsigned RETRY_CYC = `LSP_AUTORETRY_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic pwm_mode,
   input wire logic direct_level,
   input wire logic [7:0] pwm_cnt,
   input wire logic [7:0] duty,
   input wire logic fault,
   output logic hs_out,
   output logic retrying
);
   import lsp_pkg::*;

   localparam lsp_long_t RETRY_M1 = 24'(RETRY_CYC - 1);

   lsp_chan_t s;
   lsp_chan_t next_s;
   logic want;

   if (RETRY_CYC < 2 || RETRY_CYC > 24'hFFFFFF) begin : g_chk
      $error("lsp_pwm_chan retry count out of range");
   end

   // Demand level, then shutdown and retry timing
   always_comb begin
      next_s = s;
      if (pwm_mode) begin
         want = (duty == `LSP_DUTY_FULL) || (pwm_cnt < duty);
      end else begin
         want = direct_level;
      end
      if (s.shut) begin
         if (s.retry_cnt >= RETRY_M1) begin
            next_s.shut = 1'b0;
            next_s.retry_cnt = '0;
         end else begin
            next_s.retry_cnt = s.retry_cnt + 24'h000001;
         end
      end
      // A fault while driving wins over the retry release
      if (fault && s.out) begin
         next_s.shut = 1'b1;
         next_s.retry_cnt = '0;
      end
      next_s.out = want && !next_s.shut && !(fault && s.out);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign hs_out = s.out;
   assign retrying = s.shut;

   AST_FULL_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pwm_mode && duty == `LSP_DUTY_FULL && !next_s.shut && !fault |=> hs_out)
      else $error("full duty did not drive output on");
   AST_FULL_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pwm_mode && duty == 8'h00 |=> !hs_out)
      else $error("zero duty drove output on");
   AST_DIRECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pwm_mode && !next_s.shut && !fault |=> hs_out == $past(direct_level))
      else $error("output did not follow direct input");
   AST_RETRY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fault && hs_out |=> !hs_out && retrying ##1 !hs_out)
      else $error("output not held off after shutdown");
endmodule

// ==== hdl/lsp_sync.sv ====
// Purpose: Two flip-flop synchroniser for a group of pin levels
// Assumes: Each bit is an independent level
// Notes: Only the second stage may be read by other logic
`timescale 1ns/1ps
module lsp_sync #(
   parameter int unsigned W = 1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   import lsp_pkg::*;

   logic [1:0][W-1:0] s;
   logic [1:0][W-1:0] next_s;

   if (W < 1) begin : g_chk
      $error("lsp_sync width must be at least 1");
   end

   // Shift pins through two stages
   always_comb begin
      next_s = {s[0], async_in};
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s[1];
endmodule

// ==== tb/lamp_switch_pwm_output_control_test.sv ====
// Purpose: Self-checking bench of the lamp switch output control
// Assumes: Short timer parameters; inputs change at the falling edge
// Notes: Clock fail, duty limits, direct control, wake, retry, sense select
`timescale 1ns/1ps
module lamp_switch_pwm_output_control_test;
   localparam int TMO = 200;
   localparam int RTY = 100;
   localparam int FLO = 2000;
   logic ref_clk, nrst, cs_n, pwm_en, clock_sel, ext_clk, run, cal_go;
   logic [3:0] din, fault, hs, retry, sch, pins;
   logic [3:0][7:0] duty;
   logic [2:0] sense_sel;
   logic cfail, wake, stemp, soe;
   logic [31:0] half_ns, cal_ns;
   int bad_count, n_compared, cyc;

   // Input zero carries the host clock while it runs
   assign pins = {din[3:1], din[0] | ext_clk};

   lsp_output_ctrl #(.TOGGLE_TMO_CYC(TMO), .AUTORETRY_CYC(RTY), .FAIL_LO_CYC(FLO)) i_dut (
      .ref_clk(ref_clk), .nrst(nrst), .direct_inputs(pins), .cs_n(cs_n), .pwm_en(pwm_en),
      .clock_sel(clock_sel), .duty(duty), .fault(fault), .sense_sel(sense_sel),
      .high_side_outputs(hs), .retrying(retry), .clock_fail(cfail), .wake(wake),
      .sense_ch(sch), .sense_temp(stemp), .sense_feedback_pin_oe(soe));

   lsp_host_model i_host (
      .run(run), .half_ns(half_ns), .cal_go(cal_go), .cal_ns(cal_ns), .ext_clk(ext_clk), .cs_n(cs_n));

   // 20 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         results();
      end
   end

   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      bad_count = 0;
      n_compared = 0;
      nrst = 1'b0;
      din = 4'h0;
      fault = 4'h0;
      pwm_en = 1'b0;
      clock_sel = 1'b0;
      duty = '0;
      sense_sel = 3'h0;
      run = 1'b0;
      cal_go = 1'b0;
      half_ns = 32'd20000;
      cal_ns = 32'd25000;
      wait_clk(6);
      nrst = 1'b1;
      wait_clk(5);
      // Each input drives its own output and wakes
      for (int g = 0; g < 4; g++) begin
         din = 4'(1 << g);
         wait_clk(4);
         check("direct", hs, 4'(1 << g));
         check("wake", {3'h0, wake}, 4'h1);
      end
      // Activity lapses only after the toggle timeout
      din = 4'h0;
      wait_clk(TMO / 2);
      check("wake held", {3'h0, wake}, 4'h1);
      wait_clk(TMO / 2 + 10);
      check("wake lapsed", {3'h0, wake}, 4'h0);
      // Every sense selection code
      for (int s = 0; s < 8; s++) begin
         sense_sel = 3'(s);
         wait_clk(2);
         check("sense ch", sch, (s < 4) ? 4'(1 << s) : 4'h0);
         check("sense mode", {2'h0, stemp, soe}, {2'h0, s == 4, s < 5});
      end
      // Shutdown then retry after the period
      din = 4'h8;
      wait_clk(4);
      fault[3] = 1'b1;
      wait_clk(1);
      fault[3] = 1'b0;
      check("shut", {2'h0, retry[3], hs[3]}, 4'h2);
      wait_clk(RTY - 10);
      check("still off", {3'h0, hs[3]}, 4'h0);
      wait_clk(20);
      check("retried", {2'h0, retry[3], hs[3]}, 4'h1);
      din = 4'h0;
      // A 16-bit frame at 8 MHz holds chip select low only 2 us: too short to calibrate
      cal_ns = 32'd2000;
      cal_go = 1'b1;
      wait_clk(60);
      cal_go = 1'b0;
      wait_clk(2);
      // Calibrate the internal tick with a 25 us pulse
      cal_ns = 32'd25000;
      cal_go = 1'b1;
      wait_clk(520);
      cal_go = 1'b0;
      // Full and zero duty on the internal clock, no fail check there
      duty = {8'h00, 8'hFF, 8'h00, 8'hFF}; // Only fully off and fully on
      clock_sel = 1'b1;
      pwm_en = 1'b1;
      wait_clk(5);
      for (int k = 0; k < 42; k++) begin
         check("duty int", hs, 4'h5);
         wait_clk(50);
      end
      check("no fail int", {3'h0, cfail}, 4'h0);
      // Legal 25 kHz clock on input zero
      clock_sel = 1'b0;
      run = 1'b1;
      wait_clk(2 * FLO);
      check("legal clk", {3'h0, cfail}, 4'h0);
      check("duty ext", hs, 4'h5);
      // Clock far too fast; the slow half period already begun must run out first
      half_ns = 32'd200;
      wait_clk(600);
      check("fast clk", {3'h0, cfail}, 4'h1);
      pwm_en = 1'b0;
      wait_clk(3);
      check("fail off", {3'h0, cfail}, 4'h0);
      half_ns = 32'd20000;
      wait_clk(2);
      pwm_en = 1'b1;
      wait_clk(2500);
      check("relegal", {3'h0, cfail}, 4'h0);
      // Clock stops: no fail before the limit, fail after it
      run = 1'b0;
      wait_clk(FLO - 850);
      check("slow early", {3'h0, cfail}, 4'h0);
      wait_clk(950);
      check("slow clk", {3'h0, cfail}, 4'h1);
      // Mid-run reset held 10 us clears all; direct control and sense resume after it
      pwm_en = 1'b0;
      din = 4'h2;
      sense_sel = 3'h1;
      nrst = 1'b0;
      wait_clk(200);
      check("rst out", hs | retry | sch, 4'h0);
      check("rst flags", {cfail, wake, stemp, soe}, 4'h0);
      nrst = 1'b1;
      wait_clk(6);
      check("rst direct", hs, 4'h2);
      check("rst sense", sch, 4'h2);
      check("rst wake", {1'b0, cfail, wake, soe}, 4'h3);
      results();
   end
endmodule

// ==== tb/lsp_host_model.sv ====
// Purpose: Host side of the output control: external PWM clock and calibration pulse
// Assumes: Clock on input zero stands low while not running
// Notes: Chip select idles high, as with its pull-up
`timescale 1ns/1ps
module lsp_host_model (
   input wire logic run,
   input wire logic [31:0] half_ns,
   input wire logic cal_go,
   input wire logic [31:0] cal_ns,
   output logic ext_clk,
   output logic cs_n
);
   // External PWM clock for input zero, no rising edge once stopped
   initial begin
      ext_clk = 1'b0;
      forever begin
         if (!run) begin
            ext_clk = 1'b0;
            wait (run);
         end
         #(half_ns);
         ext_clk = run ? ~ext_clk : 1'b0;
      end
   end

   // Calibration low pulse of the asked length, inside or outside the window
   initial begin
      cs_n = 1'b1;
      forever begin
         @(posedge cal_go);
         cs_n = 1'b0;
         #(cal_ns) cs_n = 1'b1;
      end
   end
endmodule
